// ==== hdl/windowed_watchdog_timer.v ====
`timescale 1ns/1ps
`include "windowed_watchdog_regs.vh"

module windowed_watchdog_timer #(
  parameter TIMEOUT_SHRINK = 5'h00
) (
  input wire clock,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire specialMode,
  input wire debugMode,
  input wire stopMode,
  input wire oscillatorGood,
  input wire internalRcTick,
  input wire oscillatorTick,
  input wire auxiliaryTick,
  input wire nvLoadValid,
  input wire nvWindowMode,
  input wire [2:0] nvRateSelect,
  output reg watchdogResetRequest,
  output reg periodicTickHalt
);

  // ******************************************
  // Service sequence states
  // ******************************************
  localparam [1:0] SEQ_IDLE = 2'b01;
  localparam [1:0] SEQ_ARMED = 2'b10;

  // ******************************************
  // Declarations
  // ******************************************
  reg windowMode_reg;
  reg debugStop_reg;
  reg [2:0] rateSelect_reg;
  reg writeOnceUsed_reg;
  reg [7:0] factoryTestA_reg;
  reg [7:0] factoryTestB_reg;
  reg clkSrcSelLo_reg;
  reg clkSrcSelHi_reg;
  reg auxHalf_reg;
  reg oscGoodSeen_reg;
  reg [1:0] seqState_reg;
  reg [1:0] seqState_next;
  reg dataWrite_reg;
  reg [9:0] dataIndex_reg;
  reg [7:0] readMux;
  reg [4:0] periodExp;
  reg [4:0] shortExp;
  reg restartCtl;
  reg restartSvc;
  reg violation;
  wire addrPhase;
  wire [7:0] wrByte;
  wire ctlWrite;
  wire svcWrite;
  wire cselWrite;
  wire fieldWriteOk;
  wire watchdogEnabled;
  wire override;
  wire effWindow;
  wire oscLost;
  wire cselChange;
  wire watchdogTick;
  wire counterRun;
  wire restartAll;
  wire expired;
  wire windowOpen;

  // ******************************************
  // AHB-Lite slave, zero wait states
  // ******************************************
  assign addrPhase = hsel & htrans[1] & hready;
  assign wrByte = hwdata[7:0];
  assign ctlWrite = dataWrite_reg & (dataIndex_reg == `IDX_CONTROL);
  assign svcWrite = dataWrite_reg & (dataIndex_reg == `IDX_SERVICE);
  assign cselWrite = dataWrite_reg & (dataIndex_reg == `IDX_CLK_SEL);

  always @* begin
    case (haddr[11:2])
      `IDX_CONTROL: readMux = {windowMode_reg, debugStop_reg, 3'b000, rateSelect_reg};
      `IDX_TEST_A: readMux = factoryTestA_reg;
      `IDX_TEST_B: readMux = factoryTestB_reg;
      `IDX_CLK_SEL: readMux = {6'b000000, clkSrcSelHi_reg, clkSrcSelLo_reg};
      `IDX_STATUS: readMux = {4'b0000, windowOpen, seqState_reg[1], writeOnceUsed_reg,
        watchdogEnabled};
      default: readMux = `BYTE_ZERO;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b0;
      hrdata <= `WORD_ZERO;
      hresp <= 1'b0;
      dataWrite_reg <= 1'b0;
      dataIndex_reg <= 10'h000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dataWrite_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        dataIndex_reg <= haddr[11:2];
      end
      if (addrPhase & ~hwrite) begin
        // Service register always reads zero through the default arm
        hrdata <= {24'h000000, readMux};
      end
    end
  end

  // ******************************************
  // Control register
  // ******************************************
  assign fieldWriteOk = ~wrByte[`CTL_MASK] & (specialMode | ~writeOnceUsed_reg);
  assign watchdogEnabled = (rateSelect_reg != `RATE_OFF);
  assign override = watchdogEnabled & debugMode & ~debugStop_reg & specialMode;
  assign effWindow = windowMode_reg & ~override;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      windowMode_reg <= 1'b0;
      debugStop_reg <= 1'b0;
      rateSelect_reg <= `RATE_OFF;
      writeOnceUsed_reg <= 1'b0;
    end else if (nvLoadValid) begin
      windowMode_reg <= nvWindowMode;
      rateSelect_reg <= nvRateSelect;
    end else if (ctlWrite) begin
      if (specialMode | wrByte[`CTL_DBGSTOP]) begin
        debugStop_reg <= wrByte[`CTL_DBGSTOP];
      end
      if (fieldWriteOk) begin
        if (specialMode) begin
          windowMode_reg <= wrByte[`CTL_WINDOW];
          rateSelect_reg <= wrByte[`CTL_RATE_HI:`CTL_RATE_LO];
        end else begin
          writeOnceUsed_reg <= 1'b1;
          // Zero values have no effect in normal mode
          if (wrByte[`CTL_WINDOW]) begin
            windowMode_reg <= 1'b1;
          end
          if (wrByte[`CTL_RATE_HI:`CTL_RATE_LO] != `RATE_OFF) begin
            rateSelect_reg <= wrByte[`CTL_RATE_HI:`CTL_RATE_LO];
          end
        end
      end
    end
  end

  always @* begin
    restartCtl = 1'b0;
    if (nvLoadValid) begin
      restartCtl = (nvRateSelect != `RATE_OFF);
    end else if (ctlWrite) begin
      if (specialMode) begin
        restartCtl = 1'b1;
      end else begin
        restartCtl = (fieldWriteOk & ((wrByte[`CTL_RATE_HI:`CTL_RATE_LO] != `RATE_OFF) |
          wrByte[`CTL_WINDOW])) | (wrByte[`CTL_DBGSTOP] & ~debugStop_reg);
      end
    end
  end

  // ******************************************
  // Factory test registers
  // ******************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      factoryTestA_reg <= `TEST_RESET;
      factoryTestB_reg <= `TEST_RESET;
    end else begin
      if (dataWrite_reg & specialMode & (dataIndex_reg == `IDX_TEST_A)) begin
        factoryTestA_reg <= wrByte;
      end
      if (dataWrite_reg & specialMode & (dataIndex_reg == `IDX_TEST_B)) begin
        factoryTestB_reg <= wrByte;
      end
    end
  end

  // ******************************************
  // Clock source select and watchdog clock
  // ******************************************
  assign cselChange = cselWrite & ((wrByte[`CSEL_LO] != clkSrcSelLo_reg) |
    (wrByte[`CSEL_HI] != clkSrcSelHi_reg));
  assign oscLost = oscGoodSeen_reg & ~oscillatorGood & ~clkSrcSelHi_reg &
    clkSrcSelLo_reg;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      clkSrcSelLo_reg <= 1'b0;
      clkSrcSelHi_reg <= 1'b0;
      oscGoodSeen_reg <= 1'b0;
      auxHalf_reg <= 1'b0;
    end else begin
      oscGoodSeen_reg <= oscillatorGood;
      if (cselWrite) begin
        clkSrcSelLo_reg <= wrByte[`CSEL_LO];
        clkSrcSelHi_reg <= wrByte[`CSEL_HI];
      end
      if (auxiliaryTick) begin
        auxHalf_reg <= ~auxHalf_reg;
      end
    end
  end

  // Auxiliary ticks count only on every second pulse
  assign watchdogTick = clkSrcSelHi_reg ? (auxiliaryTick & auxHalf_reg) :
    (clkSrcSelLo_reg ? oscillatorTick : internalRcTick);
  // Stop mode halts the counter unless the auxiliary source runs it
  assign counterRun = watchdogEnabled & ~(debugMode & debugStop_reg) &
    (~stopMode | clkSrcSelHi_reg);

  always @* begin
    periodExp = `EXP_LONGEST;
    if (override) begin
      periodExp = `EXP_LONGEST;
    end else if (clkSrcSelHi_reg) begin
      case (rateSelect_reg)
        3'h1: periodExp = `EXP_AUX_1;
        3'h2: periodExp = `EXP_AUX_2;
        3'h3: periodExp = `EXP_AUX_3;
        3'h4: periodExp = `EXP_AUX_4;
        3'h5: periodExp = `EXP_AUX_5;
        3'h6: periodExp = `EXP_AUX_6;
        default: periodExp = `EXP_AUX_7;
      endcase
    end else begin
      case (rateSelect_reg)
        3'h1: periodExp = `EXP_RC_1;
        3'h2: periodExp = `EXP_RC_2;
        3'h3: periodExp = `EXP_RC_3;
        3'h4: periodExp = `EXP_RC_4;
        3'h5: periodExp = `EXP_RC_5;
        3'h6: periodExp = `EXP_RC_6;
        default: periodExp = `EXP_RC_7;
      endcase
    end
    // Shrink only for simulation; never below the window resolution
    if (periodExp > (TIMEOUT_SHRINK + `EXP_MIN)) begin
      shortExp = periodExp - TIMEOUT_SHRINK;
    end else begin
      shortExp = `EXP_MIN;
    end
  end

  // ******************************************
  // Service sequence
  // ******************************************
  always @* begin
    seqState_next = seqState_reg;
    restartSvc = 1'b0;
    violation = 1'b0;
    if (svcWrite & watchdogEnabled) begin
      if (effWindow & ~windowOpen) begin
        violation = 1'b1;
      end else begin
        case (wrByte)
          `SERVICE_FIRST: seqState_next = SEQ_ARMED;
          `SERVICE_SECOND: begin
            if (seqState_reg == SEQ_ARMED) begin
              restartSvc = 1'b1;
              seqState_next = SEQ_IDLE;
            end
          end
          default: violation = 1'b1;
        endcase
      end
    end
    if (restartAll) begin
      seqState_next = SEQ_IDLE;
    end
  end

  assign restartAll = restartCtl | restartSvc | cselChange | oscLost;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      seqState_reg <= SEQ_IDLE;
      watchdogResetRequest <= 1'b0;
      periodicTickHalt <= 1'b0;
    end else begin
      seqState_reg <= seqState_next;
      periodicTickHalt <= debugMode & debugStop_reg;
      // Request holds until the system reset clears the block
      if (violation | (expired & watchdogEnabled)) begin
        watchdogResetRequest <= 1'b1;
      end
    end
  end

  // ******************************************
  // Time-out counter
  // ******************************************
  watchdog_counter timeoutCounter (
    .clock(clock),
    .reset(reset),
    .restart(restartAll),
    .tick(watchdogTick & counterRun),
    .exponent(shortExp),
    .expired(expired),
    .windowOpen(windowOpen)
  );

endmodule // windowed_watchdog_timer

// ==== hdl/windowed_watchdog_regs.vh ====
`ifndef WINDOWED_WATCHDOG_REGS_VH
`define WINDOWED_WATCHDOG_REGS_VH

// ******************************************
// Register indices (byte address = 4 x index)
// ******************************************
`define IDX_CONTROL 10'h03c
`define IDX_TEST_A 10'h03d
`define IDX_TEST_B 10'h03e
`define IDX_SERVICE 10'h03f
`define IDX_CLK_SEL 10'h040
`define IDX_STATUS 10'h041

// ******************************************
// Field positions
// ******************************************
`define CTL_WINDOW 7
`define CTL_DBGSTOP 6
`define CTL_MASK 5
`define CTL_RATE_HI 2
`define CTL_RATE_LO 0
`define CSEL_LO 0
`define CSEL_HI 1

// ******************************************
// Values
// ******************************************
`define RATE_OFF 3'h0
`define SERVICE_FIRST 8'h55
`define SERVICE_SECOND 8'haa
`define CTL_RESET 8'h00
`define TEST_RESET 8'h00
`define CSEL_RESET 2'h0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000
`define HTRANS_IDLE 2'h0

// ******************************************
// Time-out exponents per rate select
// ******************************************
`define EXP_LONGEST 5'h18
`define EXP_MIN 5'h03
`define EXP_RC_1 5'h0e
`define EXP_RC_2 5'h10
`define EXP_RC_3 5'h12
`define EXP_RC_4 5'h14
`define EXP_RC_5 5'h16
`define EXP_RC_6 5'h17
`define EXP_RC_7 5'h18
`define EXP_AUX_1 5'h07
`define EXP_AUX_2 5'h09
`define EXP_AUX_3 5'h0b
`define EXP_AUX_4 5'h0d
`define EXP_AUX_5 5'h0f
`define EXP_AUX_6 5'h10
`define EXP_AUX_7 5'h11
`define COUNT_WIDTH 24
`define COUNT_ZERO 24'h000000
`define COUNT_ONES 24'hffffff
`define COUNT_ONE 24'h000001
`define EXP_FULL 5'h18
`define EXP_QUARTER 5'h02

`endif

// ==== hdl/watchdog_counter.v ====
`timescale 1ns/1ps
`include "windowed_watchdog_regs.vh"

module watchdog_counter (
  clock,
  reset,
  restart,
  tick,
  exponent,
  expired,
  windowOpen
);
  input wire clock;
  input wire reset;
  input wire restart;
  input wire tick;
  input wire [4:0] exponent;
  output reg expired;
  output wire windowOpen;

  reg [`COUNT_WIDTH-1:0] count_reg;
  wire [`COUNT_WIDTH-1:0] lastCount;
  wire [`COUNT_WIDTH-1:0] quarterBits;

  // ******************************************
  // Period end and final quarter
  // ******************************************
  assign lastCount = `COUNT_ONES >> (`EXP_FULL - exponent);
  assign quarterBits = count_reg >> (exponent - `EXP_QUARTER);
  // Both top bits of the period set means the last 25 percent
  assign windowOpen = (quarterBits[1:0] == 2'b11);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= `COUNT_ZERO;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart) begin
        count_reg <= `COUNT_ZERO;
      end else if (tick) begin
        // Masked compare tolerates a shorter period picked mid-run
        if ((count_reg & lastCount) == lastCount) begin
          expired <= 1'b1;
          count_reg <= `COUNT_ZERO;
        end else begin
          count_reg <= count_reg + `COUNT_ONE;
        end
      end
    end
  end
endmodule // watchdog_counter

// ==== testbench/windowed_watchdog_timer_asserts.sv ====
`timescale 1ns/1ps
`include "windowed_watchdog_regs.vh"
// ********
// Checker
// ********
module windowed_watchdog_timer_asserts #(
  parameter TIMEOUT_SHRINK = 5'h00
) (
  input logic clock,
  input logic reset,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic [31:0] hrdata,
  input logic hresp,
  input logic debugMode,
  input logic nvLoadValid,
  input logic [2:0] nvRateSelect,
  input logic watchdogResetRequest,
  input logic periodicTickHalt
);
  logic phWr;
  logic [9:0] phIdx;
  logic nvEn;
  logic offQ;
  wire take = hsel && htrans[1] && hready;
  wire ctlWr = phWr && phIdx == `IDX_CONTROL;
  wire nvOn = nvLoadValid && nvRateSelect != `RATE_OFF;
  wire svcBad = phWr && phIdx == `IDX_SERVICE && hwdata[7:0] != `SERVICE_FIRST
    && hwdata[7:0] != `SERVICE_SECOND;
  wire [9:0] aIdx = haddr[11:2];
  wire rdZ = take && !hwrite && (aIdx == `IDX_SERVICE || aIdx > `IDX_STATUS
    || aIdx < `IDX_CONTROL);
  // Enable is only tracked through loads; any control write makes it unknown
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phWr <= 1'b0;
      phIdx <= 10'h000;
      nvEn <= 1'b0;
      offQ <= 1'b1;
    end else begin
      phWr <= take && hwrite;
      phIdx <= aIdx;
      nvEn <= (nvEn || nvOn) && !ctlWr && !(nvLoadValid && !nvOn);
      if (nvOn || ctlWr) begin
        offQ <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_okay; !hresp; endproperty
  property p_ready; !$past(reset) |-> hreadyout; endproperty
  property p_upper; hrdata[31:8] == 24'h000000; endproperty
  property p_sticky; watchdogResetRequest |=> watchdogResetRequest; endproperty
  property p_nohalt; !$past(debugMode) |-> !periodicTickHalt; endproperty
  property p_bad; svcBad && nvEn |=> watchdogResetRequest; endproperty
  property p_off; offQ |=> !watchdogResetRequest; endproperty
  property p_rdzero; rdZ |=> hrdata == `WORD_ZERO; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  a_ready: assert property (p_ready) else $error("ready low");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_sticky: assert property (p_sticky) else $error("reset request dropped");
  a_nohalt: assert property (p_nohalt) else $error("halt without debug");
  a_bad: assert property (p_bad) else $error("bad service ignored");
  a_off: assert property (p_off) else $error("request while disabled");
  a_rdzero: assert property (p_rdzero) else $error("read not zero");
  c_req: cover property (watchdogResetRequest);
  c_halt: cover property (periodicTickHalt);
  c_bad: cover property (svcBad && nvEn);
endmodule // windowed_watchdog_timer_asserts

bind windowed_watchdog_timer windowed_watchdog_timer_asserts #(
  .TIMEOUT_SHRINK(TIMEOUT_SHRINK)
) chk_u (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .debugMode(debugMode), .nvLoadValid(nvLoadValid),
  .nvRateSelect(nvRateSelect), .watchdogResetRequest(watchdogResetRequest),
  .periodicTickHalt(periodicTickHalt));

// ==== testbench/windowed_watchdog_timer_test.sv ====
`timescale 1ns/1ps
`include "windowed_watchdog_regs.vh"
// ********
// Bench
// ********
module windowed_watchdog_timer_test;
  logic clock;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic specialMode = 1'b0;
  logic debugMode = 1'b0;
  logic stopMode = 1'b0;
  logic auxiliaryTick = 1'b0;
  logic internalRcTick = 1'b0;
  logic nvLoadValid = 1'b0;
  logic nvWindowMode = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] nvRateSelect = 3'h0;
  logic [31:0] q;
  wire hreadyout;
  wire hresp;
  wire watchdogResetRequest;
  wire periodicTickHalt;
  wire [31:0] hrdata;
  int fails = 0;
  int checks_done = 0;

  // Shrink of 10 makes rate 1 time out after 16 ticks, rate 2 after 64
  windowed_watchdog_timer #(.TIMEOUT_SHRINK(5'h0a)) dut_u (.clock(clock), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .specialMode(specialMode), .debugMode(debugMode), .stopMode(stopMode),
    .oscillatorGood(1'b1), .internalRcTick(internalRcTick), .oscillatorTick(1'b0),
    .auxiliaryTick(auxiliaryTick), .nvLoadValid(nvLoadValid), .nvWindowMode(nvWindowMode),
    .nvRateSelect(nvRateSelect), .watchdogResetRequest(watchdogResetRequest),
    .periodicTickHalt(periodicTickHalt));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, i, 2'h0};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= `HTRANS_IDLE;
    hwdata <= {24'h000000, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task rd(input logic [9:0] i, input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    check(q, e);
  endtask

  task req(input logic e);
    check({31'h0, watchdogResetRequest}, {31'h0, e});
  endtask

  task rst;
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    internalRcTick <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task nv(input logic w, input logic [2:0] r);
    @(posedge clock);
    nvLoadValid <= 1'b1;
    nvWindowMode <= w;
    nvRateSelect <= r;
    @(posedge clock);
    nvLoadValid <= 1'b0;
  endtask

  task t_regs;
    rd(`IDX_CONTROL, 32'h00000000);
    rd(10'h000, `WORD_ZERO);
    bus(1'b1, `IDX_TEST_A, 8'h5a);
    rd(`IDX_TEST_A, 32'h00000000);
    specialMode <= 1'b1;
    bus(1'b1, `IDX_TEST_A, 8'h5a);
    rd(`IDX_TEST_A, 32'h0000005a);
    specialMode <= 1'b0;
    $display("regs done");
  endtask

  task t_once;
    bus(1'b1, `IDX_CONTROL, 8'h23);
    rd(`IDX_CONTROL, 32'h00000000);
    bus(1'b0, `IDX_STATUS, 8'h00);
    check({31'h0, q[1]}, 32'h0);
    bus(1'b1, `IDX_CONTROL, 8'h00);
    bus(1'b0, `IDX_STATUS, 8'h00);
    check({31'h0, q[1]}, 32'h1);
    bus(1'b1, `IDX_CONTROL, 8'h03);
    rd(`IDX_CONTROL, 32'h00000000);
    bus(1'b1, `IDX_CONTROL, 8'h40);
    rd(`IDX_CONTROL, 32'h00000040);
    bus(1'b1, `IDX_CONTROL, 8'h00);
    rd(`IDX_CONTROL, 32'h00000040);
    debugMode <= 1'b1;
    repeat (3) @(posedge clock);
    check({31'h0, periodicTickHalt}, 32'h1);
    debugMode <= 1'b0;
    $display("once done");
  endtask

  task t_off;
    bus(1'b1, `IDX_SERVICE, 8'h12);
    repeat (3) @(posedge clock);
    req(1'b0);
    $display("off done");
  endtask

  task t_expire;
    nv(1'b0, 3'h1);
    repeat (12) @(posedge clock);
    req(1'b0);
    repeat (10) @(posedge clock);
    req(1'b1);
    $display("expire done");
  endtask

  task t_service;
    nv(1'b0, 3'h1);
    repeat (3) begin
      bus(1'b1, `IDX_SERVICE, `SERVICE_FIRST);
      bus(1'b1, `IDX_SERVICE, `SERVICE_FIRST);
      bus(1'b1, `IDX_SERVICE, `SERVICE_SECOND);
    end
    req(1'b0);
    bus(1'b1, `IDX_SERVICE, 8'h12);
    repeat (2) @(posedge clock);
    req(1'b1);
    $display("service done");
  endtask

  task t_window;
    nv(1'b1, 3'h2);
    repeat (52) @(posedge clock);
    bus(1'b1, `IDX_SERVICE, `SERVICE_FIRST);
    bus(1'b1, `IDX_SERVICE, `SERVICE_SECOND);
    req(1'b0);
    bus(1'b1, `IDX_SERVICE, `SERVICE_FIRST);
    repeat (2) @(posedge clock);
    req(1'b1);
    $display("window done");
  endtask

  // Select change lands two counts before the internal clock would expire;
  // the auxiliary period floors at 8 halved ticks, about 16 cycles
  task t_clock;
    auxiliaryTick <= 1'b1;
    nv(1'b0, 3'h1);
    repeat (11) @(posedge clock);
    bus(1'b1, `IDX_CLK_SEL, 8'h02);
    stopMode <= 1'b1;
    repeat (8) @(posedge clock);
    req(1'b0);
    repeat (12) @(posedge clock);
    req(1'b1);
    stopMode <= 1'b0;
    auxiliaryTick <= 1'b0;
    $display("clock done");
  endtask

  task t_special;
    @(posedge clock);
    specialMode <= 1'b1;
    nv(1'b0, 3'h1);
    repeat (5) begin
      bus(1'b1, `IDX_CONTROL, 8'h21);
      repeat (4) @(posedge clock);
    end
    req(1'b0);
    specialMode <= 1'b0;
    $display("special done");
  endtask

  initial begin
    rst();
    t_regs();
    t_once();
    t_off();
    rst();
    t_expire();
    rst();
    t_service();
    rst();
    t_window();
    rst();
    t_clock();
    rst();
    t_special();
    test_done();
  end

  // Generous limit: the full sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule // windowed_watchdog_timer_test
